// *** design/tsg_steer.sv ***
// Steering and guard-time logic of the dual-tone receiver.
`timescale 1ns/10ps
module tsg_steer
  import tsg_pkg::*;
#(
  parameter int PRESENT_CYC = GUARD_CYC, // Present guard, cycles.
  parameter int ABSENT_CYC  = GUARD_CYC, // Absent guard interval in cycles.
  parameter int DROP_CYC    = DA_CYC     // Detect-absent time in cycles.
) (
  input  wire logic            core_clk,    // Device clock, 200 MHz.
  input  wire logic            rst_b,       // Asynchronous reset, active low.
  input  wire logic            soft_clr,    // Synchronous return to idle.
  input  wire logic            tone_valid,  // Valid pair from the decoder.
  input  wire logic [3:0]      digit_in,    // Decoded digit.
  input  wire logic            guard_in,    // Guard pin input level.
  output tsg_pkg::tsg_pin_drv_t guard_drv,  // Guard pin drive and enable.
  output logic                 early_tone_detect, // Early detect.
  output logic                 charge_switch,     // Charge switch on.
  output logic                 discharge_switch,  // Discharge switch on.
  output tsg_pkg::tsg_out_t    steer_out,   // Delayed steering and digit.
  output logic                 steer_threshold    // Guard above threshold.
);
  import tsg_pkg::*;

  localparam logic [GUARD_W-1:0] PRES_TOP = GUARD_W'(PRESENT_CYC);
  localparam logic [GUARD_W-1:0] ABS_TOP  = GUARD_W'(ABSENT_CYC);
  localparam logic [DA_W-1:0]    DROP_TOP = DA_W'(DROP_CYC);

  logic                tone_s;
  tsg_state_t          state_ff;
  tsg_state_t          nxt_state;
  logic [GUARD_W-1:0]  guard_ff;
  logic [GUARD_W-1:0]  nxt_guard;
  logic [DA_W-1:0]     drop_ff;
  logic                est_ff;
  logic                steer_ff;
  logic [3:0]          digit_ff;

  // ----------------------------------------------------------------------
  // Early detect synchroniser
  // ----------------------------------------------------------------------
  // The decoder output crosses into the core clock here.
  tsg_sync u_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .d_in     (tone_valid),
    .q_out    (tone_s)
  );

  // Saturating step of the guard counter toward a limit.
  function automatic logic [GUARD_W-1:0] step_up(
    input logic [GUARD_W-1:0] v,
    input logic [GUARD_W-1:0] lim
  );
    step_up = (v >= lim) ? lim : v + GUARD_W'(1);
  endfunction

  // ----------------------------------------------------------------------
  // Guard state machine
  // ----------------------------------------------------------------------
  // Works out the next state and guard count from the synchronised detect.
  always_comb begin
    nxt_state = state_ff;
    nxt_guard = guard_ff;
    case (state_ff)
      TSG_IDLE: begin
        nxt_guard = GUARD_RST;
        if (tone_s) begin
          nxt_state = TSG_PRESENT;
        end
      end
      TSG_PRESENT: begin
        if (tone_s) begin
          nxt_guard = step_up(guard_ff, PRES_TOP);
          if (guard_ff >= PRES_TOP - GUARD_W'(1)) begin
            nxt_state = TSG_STEER;
            nxt_guard = GUARD_RST;
          end
        end else if (drop_ff >= DROP_TOP) begin
          nxt_state = TSG_IDLE;
          nxt_guard = GUARD_RST;
        end
      end
      TSG_STEER: begin
        nxt_guard = GUARD_RST;
        if (!tone_s) begin
          nxt_state = TSG_ABSENT;
        end
      end
      TSG_ABSENT: begin
        if (tone_s) begin
          nxt_state = TSG_STEER;
          nxt_guard = GUARD_RST;
        end else if (guard_ff >= ABS_TOP - GUARD_W'(1)) begin
          nxt_state = TSG_IDLE;
          nxt_guard = GUARD_RST;
        end else begin
          nxt_guard = step_up(guard_ff, ABS_TOP);
        end
      end
      default: begin
        nxt_state = TSG_IDLE;
        nxt_guard = GUARD_RST;
      end
    endcase
    if (soft_clr) begin
      nxt_state = TSG_IDLE;
      nxt_guard = GUARD_RST;
    end
  end

  // State and guard counter registers.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= TSG_IDLE;
      guard_ff <= GUARD_RST;
    end else begin
      state_ff <= nxt_state;
      guard_ff <= nxt_guard;
    end
  end

  // Dropout timer during the present guard; a short dropout only pauses.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      drop_ff <= DA_RST;
    end else if (state_ff != TSG_PRESENT || tone_s || soft_clr) begin
      drop_ff <= DA_RST;
    end else if (drop_ff < DROP_TOP) begin
      drop_ff <= drop_ff + DA_W'(1);
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Early detect is high while the synchronised pair is present, one cycle after it.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      est_ff <= 1'b0;
    end else begin
      est_ff <= tone_s && !soft_clr;
    end
  end

  // Steering and digit capture on the rising edge of steering.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      steer_ff <= 1'b0;
      digit_ff <= DIGIT_RST;
    end else begin
      steer_ff <= (nxt_state == TSG_STEER) ||
                  (nxt_state == TSG_ABSENT);
      if (state_ff == TSG_PRESENT && nxt_state == TSG_STEER) begin
        digit_ff <= digit_in;
      end
    end
  end

  // Threshold flag mirrors the comparator: high in steer and absent states.
  assign steer_threshold   = steer_ff;
  assign early_tone_detect = est_ff;
  assign steer_out.steer   = steer_ff;
  assign steer_out.digit   = digit_ff;

  // Switches and guard pin per the steering truth table.
  assign charge_switch    = !est_ff && !steer_ff;
  assign discharge_switch = est_ff && steer_ff;
  assign guard_drv.oe     = (est_ff == steer_ff);
  assign guard_drv.out    = est_ff && steer_ff;

  // The pin level is reported back only; the counter is the timing source.
  logic unused_pin;
  assign unused_pin = guard_in;

endmodule

// *** design/tsg_sync.sv ***
// Two-flop synchroniser for the early tone detect level.
`timescale 1ns/10ps
module tsg_sync (
  input  wire logic core_clk, // Device clock.
  input  wire logic rst_b,    // Asynchronous reset, active low.
  input  wire logic d_in,     // Asynchronous level.
  output logic      q_out     // Synchronised level.
);
  logic meta_ff;
  logic sync_ff;

  // ----------------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------------
  // The first stage feeds only the second stage.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= d_in;
      sync_ff <= meta_ff;
    end
  end

  assign q_out = sync_ff;
endmodule

// *** include/tsg_pkg.sv ***
// Package with types and constants of the tone steering guard-time block.
package tsg_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int GUARD_MS      = 40;
  localparam int GUARD_CYC     = (GUARD_MS * 1000000) / CLK_PERIOD_NS;
  localparam int DA_US         = 5;
  localparam int DA_CYC        = (DA_US * 1000) / CLK_PERIOD_NS;
  localparam int GUARD_W       = 24;
  localparam int DA_W          = 12;
  localparam logic [GUARD_W-1:0] GUARD_RST = 24'h000000;
  localparam logic [DA_W-1:0]    DA_RST    = 12'h000;
  localparam logic [3:0]         DIGIT_RST = 4'h0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    TSG_IDLE    = 2'b00,
    TSG_PRESENT = 2'b01,
    TSG_STEER   = 2'b11,
    TSG_ABSENT  = 2'b10
  } tsg_state_t;

  // Guard pin as two signals.
  typedef struct packed {
    logic out;
    logic oe;
  } tsg_pin_drv_t;

  // Delayed steering with its digit.
  typedef struct packed {
    logic       steer;
    logic [3:0] digit;
  } tsg_out_t;

endpackage

// *** tb/tb_top.sv ***
// Top testbench of the steering and guard-time block.
`timescale 1ns/10ps
module tb_top;
  import tsg_pkg::*;
  localparam int P = 20;
  localparam int A = 20;
  logic         core_clk = 1'b0;
  logic         rst_b = 1'b0;
  logic         soft_clr = 1'b0;
  logic         tone_valid = 1'b0;
  logic [3:0]   digit_in = 4'h0;
  logic         guard_in;
  tsg_pin_drv_t guard_drv;
  logic         early_tone_detect;
  logic         charge_switch;
  logic         discharge_switch;
  logic         steer_threshold;
  tsg_out_t     steer_out;
  logic [15:0]  sel;
  int           fail_count = 0;
  int           check_count = 0;
  int           n;
  // Clock of 5 ns period.
  always #2.5 core_clk = ~core_clk;
  tsg_steer #(.PRESENT_CYC(P), .ABSENT_CYC(A), .DROP_CYC(4)) i_dut (
    .core_clk, .rst_b, .soft_clr, .tone_valid, .digit_in, .guard_in,
    .guard_drv, .early_tone_detect, .charge_switch, .discharge_switch,
    .steer_out, .steer_threshold);
  tsg_far i_far (.core_clk, .guard_drv, .steer_out, .guard_in, .sel);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Packs early, charge, discharge, enable, drive and steering.
  function automatic logic [15:0] pins();
    return {10'h000, early_tone_detect, charge_switch, discharge_switch,
            guard_drv.oe, guard_drv.out, steer_out.steer};
  endfunction
  task automatic wt(input logic v, input int lim);
    n = 0;
    while (steer_out.steer !== v && n < lim) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task automatic tone(input logic v, input int cyc);
    tone_valid = v;
    repeat (cyc) @(negedge core_clk);
  endtask
  task automatic t_digit(input logic [3:0] d);
    digit_in = d;
    tone(1'b1, 4);
    chk(pins(), 16'h0020);
    wt(1'b1, P + 10);
    chk(16'(n + 4 >= P && n + 4 <= P + 6), 16'h0001);
    chk(pins(), 16'h002f);
    chk({12'h000, steer_out.digit}, {12'h000, d});
    chk(sel, 16'h0001 << d);
    tone(1'b0, 4);
    chk(pins(), 16'h0001);
    wt(1'b0, A + 10);
    chk(16'(n + 4 >= A && n + 4 <= A + 6), 16'h0001);
    chk(pins(), 16'h0014);
  endtask
  task automatic t_gap();
    t_digit(4'h5);
    tone(1'b1, 1);
    wt(1'b1, P + 10);
    tone(1'b0, A / 2);
    digit_in = 4'h9;
    tone(1'b1, 0);
    for (int i = 0; i < A + P; i++) begin
      @(negedge core_clk);
      chk({11'h000, steer_out.steer, steer_out.digit}, 16'h0015);
    end
    tone(1'b0, 1);
    wt(1'b0, A + 10);
    chk(pins(), 16'h0014);
  endtask
  task automatic t_drop();
    tone(1'b1, P / 2);
    tone(1'b0, 12);
    chk(pins(), 16'h0014);
    tone(1'b1, 0);
    wt(1'b1, 2 * P + 10);
    chk(16'(n >= P), 16'h0001);
    tone(1'b0, 1);
    wt(1'b0, A + 10);
  endtask
  task automatic t_clr();
    tone(1'b1, 1);
    wt(1'b1, P + 10);
    soft_clr = 1'b1;
    tone(1'b0, 3);
    soft_clr = 1'b0;
    repeat (4) @(negedge core_clk);
    chk(pins(), 16'h0014);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (10) @(negedge core_clk);
    chk(pins(), 16'h0014);
    rst_b = 1'b1;
    for (int d = 0; d < 16; d++) begin
      t_digit(4'(d));
    end
    $display("digits done");
    t_gap();
    $display("gap done");
    t_drop();
    $display("dropout done");
    t_clr();
    $display("clear done");
    close_out();
  end
  // Watchdog well beyond the expected run of about 1000 cycles.
  initial begin
    #100000;
    fail_count++;
    close_out();
  end
endmodule
bind tsg_steer tsg_checker i_chk (.core_clk, .rst_b, .tone_valid,
  .digit_in, .guard_drv, .early_tone_detect, .charge_switch,
  .discharge_switch, .steer_out, .steer_threshold);

// *** tb/tsg_checker.sv ***
// Checker of the steering and guard-time port relations.
`timescale 1ns/10ps
module tsg_checker
  import tsg_pkg::*;
(
  input wire logic                  core_clk,          // Device clock.
  input wire logic                  rst_b,             // Reset, active low.
  input wire logic                  tone_valid,        // Decoder pair.
  input wire logic [3:0]            digit_in,          // Decoded digit.
  input wire tsg_pkg::tsg_pin_drv_t guard_drv,         // Guard pin drive.
  input wire logic                  early_tone_detect, // Early detect.
  input wire logic                  charge_switch,     // Charge switch.
  input wire logic                  discharge_switch,  // Discharge switch.
  input wire tsg_pkg::tsg_out_t     steer_out,         // Steering, digit.
  input wire logic                  steer_threshold    // Above threshold.
);
  // All relations are sampled on the one device clock.
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_idle_pin: assert property (!early_tone_detect && !steer_out.steer |->
    guard_drv.oe && !guard_drv.out) else $error("idle pin not low");
  a_charge_on: assert property (charge_switch ==
    (!early_tone_detect && !steer_out.steer)) else $error("charge wrong");
  a_discharge_on: assert property (discharge_switch ==
    (early_tone_detect && steer_out.steer)) else $error("discharge wrong");
  a_pin_released: assert property (early_tone_detect != steer_out.steer
    |-> !guard_drv.oe) else $error("pin not released");
  a_pin_high: assert property (early_tone_detect && steer_out.steer |->
    guard_drv.oe && guard_drv.out) else $error("pin not high");
  a_early_lag: assert property ($rose(early_tone_detect) |->
    $past(tone_valid, 3)) else $error("early detect too soon");
  a_digit_latch: assert property ($rose(steer_out.steer) |->
    steer_out.digit == $past(digit_in)) else $error("digit not latched");
  a_digit_hold: assert property (steer_out.steer && $past(steer_out.steer)
    |-> $stable(steer_out.digit)) else $error("digit moved");
  a_thresh_same: assert property (steer_threshold == steer_out.steer)
    else $error("threshold flag differs");
endmodule

// *** tb/tsg_far.sv ***
// Model of the guard pin network and the downstream select decoder.
`timescale 1ns/10ps
module tsg_far
  import tsg_pkg::*;
(
  input wire logic                  core_clk,  // Device clock.
  input wire tsg_pkg::tsg_pin_drv_t guard_drv, // Pin drive from the block.
  input wire tsg_pkg::tsg_out_t     steer_out, // Steering and digit.
  output logic                      guard_in,  // Level seen at the pin.
  output logic [15:0]               sel        // One-hot function select.
);
  logic lvl_ff;
  // A released pin shows a level that changes every cycle.
  always_ff @(posedge core_clk) begin
    lvl_ff <= guard_drv.oe ? ~guard_drv.out : ~lvl_ff;
  end
  assign guard_in = guard_drv.oe ? guard_drv.out : lvl_ff;
  // The digit is decoded only while steering is high.
  assign sel = steer_out.steer ? (16'h0001 << steer_out.digit) : 16'h0000;
endmodule
